// ---- hw/ioirt_defines.vh ----
// Constants of the interrupt router: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the design files of the router.
`ifndef IOIRT_DEFINES_VH
`define IOIRT_DEFINES_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IOIRT_OFF_SEL      12'h000
`define IOIRT_OFF_VEC      12'h004
`define IOIRT_OFF_CFG      12'h008
`define IOIRT_OFF_BDF      12'h00C
`define IOIRT_OFF_EOI      12'h010
`define IOIRT_OFF_STAT     12'h014
`define IOIRT_OFF_CLR      12'h018
`define IOIRT_OFF_EN       12'h01C
`define IOIRT_OFF_MSGADDR  12'h020
`define IOIRT_OFF_SWREQ    12'h024
`define IOIRT_OFF_LEVEL    12'h028
// ****************************************************************
// Fields of the per-input configuration word
// ****************************************************************
`define IOIRT_CFG_MASK     0
`define IOIRT_CFG_LEVEL    1
`define IOIRT_CFG_POL_LOW  2
`define IOIRT_CFG_PRI_LSB  4
`define IOIRT_CFG_PRI_W    4
// ****************************************************************
// Reset values
// ****************************************************************
`define IOIRT_RST_CFG      8'h01
`define IOIRT_RST_VEC      8'h00
`define IOIRT_RST_BDF      16'h00F8
`define IOIRT_RST_MSGADDR  32'hFEE00000
// ****************************************************************
// Status bits
// ****************************************************************
`define IOIRT_ST_SENT      0
`define IOIRT_ST_EOI       1
`define IOIRT_ST_EOIFWD    2
`define IOIRT_ST_W         3
`endif

// ---- hw/ioirt_sync.v ----
// Three-stage synchroniser for one asynchronous level, with a glitch filter.
// Assumes a single clock CLK and a synchronous active-high reset.
`timescale 1ns/100ps
module ioirt_sync (
   input  wire clk,
   input  wire srst,
   input  wire d,
   output reg  q
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   // The output moves only once the second and third stages agree.
   always @(posedge clk) begin
      if (srst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q      <= 1'b0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q <= s3_reg;
         end
      end
   end
endmodule // ioirt_sync

// ---- hw/ioirt_input.v ----
// One interrupt input slot: trigger detection and the pending/in-service state.
// Assumes a request level already in the CLK domain, polarity applied by the caller.
`timescale 1ns/100ps
module ioirt_input (
   input  wire clk,
   input  wire srst,
   input  wire req,
   input  wire level_mode,
   input  wire masked,
   input  wire taken,
   input  wire eoi,
   output wire pend
);
   reg req_d_reg;
   reg pend_reg;
   reg irr_reg;
   wire rise;
   assign rise = req & ~req_d_reg;
   assign pend = pend_reg & ~masked & ~irr_reg;
   always @(posedge clk) begin
      if (srst) begin
         req_d_reg <= 1'b0;
         pend_reg  <= 1'b0;
         irr_reg   <= 1'b0;
      end else begin
         req_d_reg <= req;
         // Level inputs stay pending while the request holds, so one still asserted
         // after its end of interrupt is delivered again.
         if (level_mode) begin
            pend_reg <= req & ~(taken);
         // Edges seen while masked are dropped; this also hides the false edge of a line
         // whose polarity is still at its reset value.
         end else if (rise & ~masked) begin
            pend_reg <= 1'b1;
         end else if (taken) begin
            pend_reg <= 1'b0;
         end
         // Level inputs wait for end of interrupt before another message.
         if (taken & level_mode) begin
            irr_reg <= 1'b1;
         end else if (eoi) begin
            irr_reg <= 1'b0;
         end
      end
   end
endmodule // ioirt_input

// ---- hw/ioirt_router.v ----
// Interrupt router: gathers inputs, picks by programmed priority, sends memory writes.
// Assumes APB master on CLK, asynchronous pins synchronised here, message port handshake.
`timescale 1ns/100ps
`include "ioirt_defines.vh"
module ioirt_router #(
   parameter NIRQ = 120,
   parameter PRI_W = 4
) (
   input  wire        CLK,
   input  wire        SRST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire        SERIAL_IRQ_LINE_A,
   input  wire [3:0]  SERIAL_IRQ_LINES,
   input  wire        PCI_IRQ_LINE_A_PIN,
   input  wire        INTX_MSG_VALID,
   input  wire        INTX_MSG_ASSERT,
   input  wire [1:0]  INTX_MSG_LINE,
   input  wire        CASCADE_IRQ,
   input  wire        TIMER0_IRQ,
   input  wire        HPT0_LEGACY_IRQ,
   input  wire        RTC_IRQ,
   input  wire        HPT1_LEGACY_IRQ,
   input  wire [3:0]  INTERNAL_PCI_E_TO_H_N,
   input  wire [NIRQ-1:0] INTERNAL_IRQ,
   output reg         MSG_VALID,
   output reg  [31:0] MSG_ADDR,
   output reg  [31:0] MSG_DATA,
   output reg  [15:0] MSG_REQ_ID,
   input  wire        MSG_READY,
   output reg         EOI_FWD_VALID,
   output reg  [7:0]  EOI_FWD_VECTOR,
   output reg         IRQ
);
   // ****************************************************************
   // Register file
   // ****************************************************************
   reg  [6:0]            sel_reg;
   reg  [7:0]            vec_reg [0:NIRQ-1];
   reg  [7:0]            cfg_reg [0:NIRQ-1];
   reg  [15:0]           bdf_reg;
   reg  [31:0]           maddr_reg;
   reg  [NIRQ-1:0]       swreq_reg;
   reg  [`IOIRT_ST_W-1:0] stat_reg;
   reg  [`IOIRT_ST_W-1:0] en_reg;
   reg                   eoi_pulse_reg;
   reg  [7:0]            eoi_vec_reg;
   reg  [3:0]            intx_reg;
   wire                  acc;
   wire                  wr;
   wire [NIRQ-1:0]       req_lvl;
   wire [NIRQ-1:0]       pend;
   wire [NIRQ-1:0]       taken;
   wire [NIRQ-1:0]       eoi_hit;
   wire                  ser_a;
   wire [3:0]            ser_bd;
   wire                  pin_a;
   reg  [NIRQ-1:0]       raw;
   reg  [6:0]            best_idx;
   reg                   best_ok;
   reg  [PRI_W-1:0]      best_pri;
   reg  [PRI_W-1:0]      cur_pri;
   reg                   busy_reg;
   reg  [6:0]            sent_idx_reg;
   reg  [`IOIRT_ST_W-1:0] ev;
   wire                  sel_ok;
   integer               i;
   integer               m;
   integer               n;
   // Taken in the cycle before the ready pulse, not in it; a request held past the ready cycle is taken again.
   assign acc = PSEL & PENABLE & ~PREADY;
   assign wr  = acc & PWRITE;
   // The select field is wider than the table; indices past it read zero and write nothing.
   assign sel_ok = (sel_reg < NIRQ);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // The low-active lines pass inverted, so the stages' reset value reads as idle.
   ioirt_sync u_sync_a (
      .clk  (CLK),
      .srst (SRST),
      .d    (~PCI_IRQ_LINE_A_PIN),
      .q    (pin_a)
   );
   ioirt_sync u_sync_sa (
      .clk  (CLK),
      .srst (SRST),
      .d    (~SERIAL_IRQ_LINE_A),
      .q    (ser_a)
   );
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ser
         ioirt_sync u_sync (
            .clk  (CLK),
            .srst (SRST),
            .d    (~SERIAL_IRQ_LINES[g]),
            .q    (ser_bd[g])
         );
      end
   endgenerate
   // ****************************************************************
   // Source mapping
   // ****************************************************************
   // A line of A to H is asserted here while any of its low-active sharers pulls it down.
   // Stream bit 0 carries no line; input 16 takes its stream request from line A alone.
   always @* begin
      raw = INTERNAL_IRQ | swreq_reg;
      raw[0] = CASCADE_IRQ;
      raw[2] = TIMER0_IRQ | HPT0_LEGACY_IRQ;
      raw[8] = RTC_IRQ | HPT1_LEGACY_IRQ;
      raw[16] = ser_a | pin_a | intx_reg[0] | INTERNAL_IRQ[16];
      for (m = 1; m < 4; m = m + 1) begin
         raw[16+m] = ser_bd[m] | intx_reg[m] | INTERNAL_IRQ[16+m];
      end
      for (m = 0; m < 4; m = m + 1) begin
         raw[20+m] = ~INTERNAL_PCI_E_TO_H_N[m];
      end
   end
   // ****************************************************************
   // Input slots
   // ****************************************************************
   generate
      for (g = 0; g < NIRQ; g = g + 1) begin : g_in
         // Polarity bit inverts so software sees the documented sense.
         assign req_lvl[g] = raw[g] ^ cfg_reg[g][`IOIRT_CFG_POL_LOW] ^ (g >= 16 && g < 24);
         assign taken[g]   = MSG_VALID & MSG_READY & (sent_idx_reg == g);
         assign eoi_hit[g] = eoi_pulse_reg & (vec_reg[g] == eoi_vec_reg);
         ioirt_input u_in (
            .clk        (CLK),
            .srst       (SRST),
            .req        (req_lvl[g]),
            .level_mode (cfg_reg[g][`IOIRT_CFG_LEVEL]),
            .masked     (cfg_reg[g][`IOIRT_CFG_MASK]),
            .taken      (taken[g]),
            .eoi        (eoi_hit[g]),
            .pend       (pend[g])
         );
      end
   endgenerate
   // ****************************************************************
   // Priority pick
   // ****************************************************************
   // A linear search over all inputs; ties fall to the lowest number.
   // One full search per cycle is a long path, which the slow clock easily absorbs.
   always @* begin
      best_ok  = 1'b0;
      best_idx = 7'h00;
      best_pri = {PRI_W{1'b0}};
      cur_pri  = {PRI_W{1'b0}};
      for (n = 0; n < NIRQ; n = n + 1) begin
         cur_pri = cfg_reg[n][`IOIRT_CFG_PRI_LSB +: PRI_W];
         if (pend[n] && (!best_ok || cur_pri > best_pri)) begin
            best_ok  = 1'b1;
            best_idx = n[6:0];
            best_pri = cur_pri;
         end
      end
   end
   // ****************************************************************
   // APB slave and message engine
   // ****************************************************************
   always @* begin
      ev = {`IOIRT_ST_W{1'b0}};
      ev[`IOIRT_ST_SENT]   = MSG_VALID & MSG_READY;
      ev[`IOIRT_ST_EOI]    = eoi_pulse_reg;
      ev[`IOIRT_ST_EOIFWD] = eoi_pulse_reg;
   end
   always @(posedge CLK) begin
      if (SRST) begin
         sel_reg        <= 7'h00;
         bdf_reg        <= `IOIRT_RST_BDF;
         maddr_reg      <= `IOIRT_RST_MSGADDR;
         swreq_reg      <= {NIRQ{1'b0}};
         stat_reg       <= {`IOIRT_ST_W{1'b0}};
         en_reg         <= {`IOIRT_ST_W{1'b0}};
         eoi_pulse_reg  <= 1'b0;
         eoi_vec_reg    <= 8'h00;
         intx_reg       <= 4'h0;
         busy_reg       <= 1'b0;
         sent_idx_reg   <= 7'h00;
         PRDATA         <= 32'h00000000;
         PREADY         <= 1'b0;
         PSLVERR        <= 1'b0;
         MSG_VALID      <= 1'b0;
         MSG_ADDR       <= 32'h00000000;
         MSG_DATA       <= 32'h00000000;
         MSG_REQ_ID     <= 16'h0000;
         EOI_FWD_VALID  <= 1'b0;
         EOI_FWD_VECTOR <= 8'h00;
         for (i = 0; i < NIRQ; i = i + 1) begin
            vec_reg[i] <= `IOIRT_RST_VEC;
            cfg_reg[i] <= `IOIRT_RST_CFG;
         end
      end else begin
         PREADY        <= acc;
         PSLVERR       <= 1'b0;
         eoi_pulse_reg <= 1'b0;
         if (INTX_MSG_VALID) begin
            intx_reg[INTX_MSG_LINE] <= INTX_MSG_ASSERT;
         end
         if (acc) begin
            PRDATA <= 32'h00000000;
            case (PADDR)
               `IOIRT_OFF_SEL: begin
                  if (PWRITE) sel_reg <= PWDATA[6:0];
                  PRDATA <= {25'h0000000, sel_reg};
               end
               `IOIRT_OFF_VEC: begin
                  if (PWRITE && sel_ok) vec_reg[sel_reg] <= PWDATA[7:0];
                  if (sel_ok) PRDATA <= {24'h000000, vec_reg[sel_reg]};
               end
               `IOIRT_OFF_CFG: begin
                  if (PWRITE && sel_ok) cfg_reg[sel_reg] <= PWDATA[7:0];
                  if (sel_ok) PRDATA <= {24'h000000, cfg_reg[sel_reg]};
               end
               `IOIRT_OFF_BDF: begin
                  if (PWRITE) bdf_reg <= PWDATA[15:0];
                  PRDATA <= {16'h0000, bdf_reg};
               end
               `IOIRT_OFF_EOI: begin
                  // Every input holding this vector re-arms, so sharers of a vector finish together.
                  if (PWRITE) begin
                     eoi_pulse_reg <= 1'b1;
                     eoi_vec_reg   <= PWDATA[7:0];
                  end
               end
               `IOIRT_OFF_STAT: PRDATA <= {29'h00000000, stat_reg};
               `IOIRT_OFF_CLR: ;
               `IOIRT_OFF_EN: begin
                  if (PWRITE) en_reg <= PWDATA[`IOIRT_ST_W-1:0];
                  PRDATA <= {29'h00000000, en_reg};
               end
               `IOIRT_OFF_MSGADDR: begin
                  if (PWRITE) maddr_reg <= PWDATA;
                  PRDATA <= maddr_reg;
               end
               `IOIRT_OFF_SWREQ: begin
                  if (PWRITE && sel_ok) swreq_reg[sel_reg] <= PWDATA[0];
                  if (sel_ok) PRDATA <= {31'h00000000, swreq_reg[sel_reg]};
               end
               `IOIRT_OFF_LEVEL: if (sel_ok) PRDATA <= {31'h00000000, req_lvl[sel_reg]};
               default: PSLVERR <= 1'b1;
            endcase
         end
         // Set wins over a clear written in the same cycle.
         if (wr && PADDR == `IOIRT_OFF_CLR) begin
            stat_reg <= (stat_reg & ~PWDATA[`IOIRT_ST_W-1:0]) | ev;
         end else begin
            stat_reg <= stat_reg | ev;
         end
         // End of interrupt goes only to the PCI Express side port.
         EOI_FWD_VALID  <= eoi_pulse_reg;
         EOI_FWD_VECTOR <= eoi_vec_reg;
         // One message in flight; the next pick waits for the handshake, so late priority
         // changes still count.
         if (MSG_VALID & MSG_READY) begin
            MSG_VALID <= 1'b0;
            busy_reg  <= 1'b0;
         end else if (!busy_reg && best_ok) begin
            busy_reg     <= 1'b1;
            sent_idx_reg <= best_idx;
            MSG_VALID    <= 1'b1;
            MSG_ADDR     <= maddr_reg;
            MSG_DATA     <= {16'h0000, cfg_reg[best_idx][`IOIRT_CFG_LEVEL], 7'h00,
                             vec_reg[best_idx]};
            MSG_REQ_ID   <= bdf_reg;
         end
      end
   end
   // ****************************************************************
   // Interrupt output
   // ****************************************************************
   // The level follows status and enable one cycle late, straight from its own flip-flop.
   always @(posedge CLK) begin
      if (SRST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(stat_reg & en_reg);
      end
   end
endmodule // ioirt_router

// ---- dv/ioirt_lapic.sv ----
// Message sink standing for the processor interrupt units on the router's message port.
// Assumes the router's CLK and SRST; the bench sets how many cycles each message stalls.
`timescale 1ns/100ps
// ****************************************************************
// Message sink model
// ****************************************************************
module ioirt_lapic (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        msg_valid,
   input  wire logic [31:0] msg_data,
   input  wire logic [15:0] msg_req_id,
   input  wire logic [3:0]  wait_cyc,
   output logic             msg_ready,
   output logic             got,
   output logic [31:0]      got_data,
   output logic [15:0]      got_req_id
);
   logic [3:0] cnt;
   // A plain memory write is accepted; nothing is ever acknowledged back.
   always @(posedge clk) begin
      got <= 1'b0;
      if (srst) begin
         msg_ready <= 1'b0;
         cnt <= 4'h0;
      end else if (msg_valid && msg_ready) begin
         msg_ready <= 1'b0;
         cnt <= 4'h0;
         got <= 1'b1;
         got_data <= msg_data;
         got_req_id <= msg_req_id;
      end else if (msg_valid && cnt >= wait_cyc) begin
         msg_ready <= 1'b1;
      end else if (msg_valid) begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule // ioirt_lapic

// ---- dv/ioirt_router_assertions.sv ----
// Port checks of the interrupt router: bus answer, message handshake, end of interrupt.
// Assumes the router's single clock and synchronous reset; bound to every router instance.
`timescale 1ns/100ps
`include "ioirt_defines.vh"
// ****************************************************************
// Checker
// ****************************************************************
module ioirt_chk (
   input wire logic        CLK,
   input wire logic        SRST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        MSG_VALID,
   input wire logic [31:0] MSG_ADDR,
   input wire logic [31:0] MSG_DATA,
   input wire logic [15:0] MSG_REQ_ID,
   input wire logic        MSG_READY,
   input wire logic        EOI_FWD_VALID,
   input wire logic [7:0]  EOI_FWD_VECTOR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   // Shadow copies of what software wrote, so each message and each forwarded end of interrupt can be tied to it.
   logic [15:0] bdf_reg;
   logic [31:0] addr_reg;
   logic [7:0]  eoi_reg;
   wire         wr_ok = PSEL && PENABLE && PWRITE && !PREADY;
   always @(posedge CLK) begin
      if (SRST) begin
         bdf_reg <= `IOIRT_RST_BDF;
         addr_reg <= `IOIRT_RST_MSGADDR;
         eoi_reg <= 8'h00;
      end else if (wr_ok && PADDR == `IOIRT_OFF_BDF) begin
         bdf_reg <= PWDATA[15:0];
      end else if (wr_ok && PADDR == `IOIRT_OFF_MSGADDR) begin
         addr_reg <= PWDATA;
      end else if (wr_ok && PADDR == `IOIRT_OFF_EOI) begin
         eoi_reg <= PWDATA[7:0];
      end
   end
   sequence s_access;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_eoi_wr;
      wr_ok && PADDR == `IOIRT_OFF_EOI;
   endsequence
   sequence s_eoi_out;
      EOI_FWD_VALID && EOI_FWD_VECTOR == eoi_reg;
   endsequence
   a_apb_answer: assert property (s_access |=> PREADY) else $error("no bus answer");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
   a_err_unmapped: assert property (PSLVERR |-> PREADY
      && (PADDR[1:0] != 2'b00 || PADDR > `IOIRT_OFF_LEVEL)) else $error("error on mapped address");
   a_msg_hold: assert property (MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_DATA)
      && $stable(MSG_REQ_ID) && $stable(MSG_ADDR)) else $error("message changed while waiting");
   a_msg_drop: assert property (MSG_VALID && MSG_READY |=> !MSG_VALID)
      else $error("message held after handshake");
   a_msg_req_id: assert property ($rose(MSG_VALID) |-> MSG_REQ_ID == bdf_reg)
      else $error("wrong requester id");
   a_msg_addr: assert property ($rose(MSG_VALID) |-> MSG_ADDR == addr_reg)
      else $error("wrong message address");
   a_eoi_forward: assert property (s_eoi_wr |-> ##[1:4] s_eoi_out)
      else $error("end of interrupt not forwarded");
   a_eoi_pulse: assert property (EOI_FWD_VALID |=> !EOI_FWD_VALID)
      else $error("forward pulse too long");
endmodule // ioirt_chk
bind ioirt_router ioirt_chk chk (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .MSG_VALID(MSG_VALID), .MSG_ADDR(MSG_ADDR), .MSG_DATA(MSG_DATA), .MSG_REQ_ID(MSG_REQ_ID),
   .MSG_READY(MSG_READY), .EOI_FWD_VALID(EOI_FWD_VALID), .EOI_FWD_VECTOR(EOI_FWD_VECTOR));

// ---- dv/tb_top.sv ----
// Self-checking bench of the interrupt router, with a message sink and an expected queue.
// Assumes the router and its header under hw, the sink and checker compiled before it.
`timescale 1ns/100ps
`include "ioirt_defines.vh"
// ****************************************************************
// Bench
// ****************************************************************
module tb_top;
   logic         CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PIN_N, INTX_V, INTX_A;
   logic         MSG_VALID, MSG_READY, EOI_FWD_VALID, IRQ, got, er, SER_A;
   logic [1:0]   INTX_L;
   logic [3:0]   SER_N, PCI_EH_N, wait_cyc;
   logic [4:0]   leg;
   logic [7:0]   EOI_FWD_VECTOR;
   logic [11:0]  PADDR;
   logic [15:0]  MSG_REQ_ID, got_req_id, bdf;
   logic [31:0]  PWDATA, PRDATA, MSG_ADDR, MSG_DATA, got_data, rd, r, exp_eoi;
   logic [31:0]  seed = 32'h0001796A;
   logic [31:0]  exp_q[$];
   logic [119:0] INT_IRQ;
   int           errors = 0, checks_done = 0, n_msg = 0, n_eoi = 0, nexp = 0, ne = 0, idx;
   ioirt_router dut (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .SERIAL_IRQ_LINE_A(SER_A), .SERIAL_IRQ_LINES(SER_N), .PCI_IRQ_LINE_A_PIN(PIN_N),
      .INTX_MSG_VALID(INTX_V), .INTX_MSG_ASSERT(INTX_A), .INTX_MSG_LINE(INTX_L),
      .CASCADE_IRQ(leg[0]), .TIMER0_IRQ(leg[1]), .HPT0_LEGACY_IRQ(leg[2]), .RTC_IRQ(leg[3]),
      .HPT1_LEGACY_IRQ(leg[4]), .INTERNAL_PCI_E_TO_H_N(PCI_EH_N), .INTERNAL_IRQ(INT_IRQ),
      .MSG_VALID(MSG_VALID), .MSG_ADDR(MSG_ADDR), .MSG_DATA(MSG_DATA), .MSG_REQ_ID(MSG_REQ_ID),
      .MSG_READY(MSG_READY), .EOI_FWD_VALID(EOI_FWD_VALID), .EOI_FWD_VECTOR(EOI_FWD_VECTOR),
      .IRQ(IRQ));
   ioirt_lapic sink (.clk(CLK), .srst(SRST), .msg_valid(MSG_VALID), .msg_data(MSG_DATA),
      .msg_req_id(MSG_REQ_ID), .wait_cyc(wait_cyc), .msg_ready(MSG_READY), .got(got),
      .got_data(got_data), .got_req_id(got_req_id));
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // The access wait has no limit of its own; only the watchdog ends a hung access.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      cmp(s, e, rd);
   endtask
   task automatic cfg(input int i, input logic [7:0] v, input logic [7:0] c);
      apb(1'b1, `IOIRT_OFF_SEL, i);
      apb(1'b1, `IOIRT_OFF_VEC, {24'h0, v});
      apb(1'b1, `IOIRT_OFF_CFG, {24'h0, c});
   endtask
   task automatic want(input logic [7:0] v, input logic lvl);
      exp_q.push_back({bdf, lvl, 7'h00, v});
   endtask
   task automatic wait_msgs();
      int t;
      t = 0;
      while (n_msg < nexp && t < 300) begin
         @(posedge CLK);
         t++;
      end
      cmp("message count", nexp, n_msg);
   endtask
   task automatic eoi(input logic [7:0] v);
      exp_eoi = {24'h0, v};
      ne++;
      apb(1'b1, `IOIRT_OFF_EOI, {24'h0, v});
      repeat (6) @(posedge CLK);
      cmp("eoi count", ne, n_eoi);
   endtask
   // Line 16 is driven here by the PCI pin or stream line A, 17 by an INTx message, 18 by a stream request and 20 by an E to H input.
   task automatic line(input int j, input logic on);
      @(posedge CLK);
      case (j)
         0: PIN_N <= ~on;
         1: {INTX_V, INTX_A, INTX_L} <= {1'b1, on, 2'h1};
         2: SER_N[2] <= ~on;
         4: SER_A <= ~on;
         default: PCI_EH_N[0] <= ~on;
      endcase
      @(posedge CLK);
      INTX_V <= 1'b0;
   endtask
   // Model side: every delivered message must match the head of the expected queue.
   always @(posedge CLK) begin
      if (got === 1'b1) begin
         r = exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
         cmp("message", r, {got_req_id, got_data[15], 7'h00, got_data[7:0]});
         cmp("message spare", 32'h0, got_data & 32'hFFFF7F00);
         n_msg++;
      end
      if (EOI_FWD_VALID === 1'b1) begin
         cmp("eoi vector", exp_eoi, {24'h0, EOI_FWD_VECTOR});
         n_eoi++;
      end
   end
   initial begin
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA, INTX_V, INTX_A, INTX_L, leg, INT_IRQ} = '0;
      {SER_A, PIN_N, SER_N, PCI_EH_N, wait_cyc} = 14'h3FF0;
      SRST = 1'b1;
      repeat (12) @(posedge CLK);
      SRST <= 1'b0;
      rdchk(`IOIRT_OFF_BDF, {16'h0, `IOIRT_RST_BDF}, "bdf reset");
      rdchk(`IOIRT_OFF_MSGADDR, `IOIRT_RST_MSGADDR, "address reset");
      rdchk(`IOIRT_OFF_CFG, {24'h0, `IOIRT_RST_CFG}, "cfg reset");
      apb(1'b0, 12'hFFC, 32'h0);
      cmp("unmapped error", 32'h1, {31'h0, er});
      $display("test reset done");
      r = rnd();
      bdf = r[15:0];
      apb(1'b1, `IOIRT_OFF_BDF, {16'h0, bdf});
      for (int k = 0; k < 5; k++) begin
         idx = (k == 0) ? 0 : (k < 3) ? 2 : 8;
         r = rnd();
         wait_cyc <= r[3:0];
         cfg(idx, 8'h40 | k[7:0], 8'h00);
         want(8'h40 | k[7:0], 1'b0);
         leg[k] <= 1'b1;
         nexp++;
         wait_msgs();
         leg[k] <= 1'b0;
      end
      $display("test legacy sources done");
      r = rnd();
      idx = 24 + int'(r % 96);
      cfg(3, 8'h33, 8'h20);
      cfg(10, 8'h3A, 8'h90);
      cfg(idx, 8'h77, 8'h50);
      want(8'h3A, 1'b0);
      want(8'h77, 1'b0);
      want(8'h33, 1'b0);
      INT_IRQ <= (120'h1 << 3) | (120'h1 << 10) | (120'h1 << idx);
      nexp += 3;
      wait_msgs();
      INT_IRQ <= '0;
      $display("test priority done");
      for (int j = 0; j < 5; j++) begin
         idx = (j == 3) ? 20 : (j == 4) ? 16 : 16 + j;
         cfg(idx, 8'h50 | j[7:0], 8'h06);
         want(8'h50 | j[7:0], 1'b1);
         line(j, 1'b1);
         nexp++;
         wait_msgs();
         line(j, 1'b0);
         repeat (20) @(posedge CLK);
         eoi(8'h50 | j[7:0]);
      end
      want(8'h51, 1'b1);
      want(8'h51, 1'b1);
      line(1, 1'b1);
      nexp++;
      wait_msgs();
      eoi(8'h51);
      nexp++;
      wait_msgs();
      line(1, 1'b0);
      eoi(8'h51);
      cfg(5, 8'h05, 8'h01);
      INT_IRQ <= 120'h20;
      repeat (30) @(posedge CLK);
      cmp("no extra message", nexp, n_msg);
      INT_IRQ <= '0;
      $display("test level lines done");
      rdchk(`IOIRT_OFF_STAT, 32'h7, "status");
      cmp("irq disabled", 32'h0, {31'h0, IRQ});
      apb(1'b1, `IOIRT_OFF_EN, 32'h7);
      repeat (2) @(posedge CLK);
      cmp("irq enabled", 32'h1, {31'h0, IRQ});
      apb(1'b1, `IOIRT_OFF_CLR, 32'h7);
      rdchk(`IOIRT_OFF_STAT, 32'h0, "status cleared");
      cmp("irq cleared", 32'h0, {31'h0, IRQ});
      cmp("queue left", 32'h0, exp_q.size());
      $display("test interrupt done");
      end_sim();
   end
   initial begin
      repeat (30000) @(posedge CLK);
      errors++;
      end_sim();
   end
endmodule // tb_top
